/* src/msf_pkg.sv */
// package: register map, codes and timing counts for the motor sequencer fault handler
package msf_pkg;
	// ----------------------------------------
	// register offsets (word index = byte address / 4)
	// ----------------------------------------
	localparam logic [7:0] ADDR_COMMAND = 8'h00;
	localparam logic [7:0] ADDR_STAGE = 8'h04;
	localparam logic [7:0] ADDR_STATUS_FLAGS = 8'h08;
	localparam logic [7:0] ADDR_FAULT_BITS = 8'h0c;
	localparam logic [7:0] ADDR_FAULT_CLEAR = 8'h10;
	localparam logic [7:0] ADDR_FAULT_DISABLE = 8'h14;
	localparam logic [7:0] ADDR_IRQ_STATUS = 8'h18;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h1c;

	// ----------------------------------------
	// command codes
	// ----------------------------------------
	localparam logic [15:0] CMD_START = 16'h0002;
	localparam logic [15:0] CMD_STOP = 16'h0004;

	// ----------------------------------------
	// stage codes, one-hot
	// ----------------------------------------
	typedef enum logic [15:0] {
		ST_IDLE = 16'h0001,
		ST_PRECHARGE = 16'h0002,
		ST_OFFSET = 16'h0004,
		ST_CS_CHECK = 16'h0008,
		ST_CS_BRAKE = 16'h0010,
		ST_PARK1 = 16'h0020,
		ST_PARK2 = 16'h0040,
		ST_OPEN_LOOP = 16'h0080,
		ST_TRANSITION = 16'h0100,
		ST_CLOSED_LOOP = 16'h0200,
		ST_FAULT = 16'h0400,
		ST_VF = 16'h4000
	} msf_stage_e;

	// ----------------------------------------
	// fault bit positions
	// ----------------------------------------
	localparam int FLT_GATE_KILL = 0;
	localparam int FLT_CRIT_OV = 1;
	localparam int FLT_PFC_GATE_KILL = 11;
	localparam int FLT_WIDTH = 13;
	localparam logic [12:0] FLT_UNMASKABLE = 13'h0803;

	// ----------------------------------------
	// status flag positions
	// ----------------------------------------
	localparam int SF_START_OK = 0;
	localparam int SF_CLOSED_LOOP = 1;
	localparam int SF_PARK_DONE = 2;
	localparam int SF_PARK_ONE = 3;
	localparam int SF_START_FAIL = 4;
	localparam int SF_TWO_PHASE = 5;

	// ----------------------------------------
	// interrupt sources
	// ----------------------------------------
	localparam int IRQ_FAULT = 0;
	localparam int IRQ_START_OK = 1;
	localparam int IRQ_WIDTH = 2;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_HZ = 20_000_000;
	localparam int STEP_US = 100;
	localparam int STEP_CYCLES = STEP_US * (CLK_HZ / 1_000_000);
	localparam int PARK_US = 400;
	localparam int PARK_CYCLES = PARK_US * (CLK_HZ / 1_000_000);
	localparam int PARK_ONE_CYCLES = PARK_CYCLES / 4;
endpackage : msf_pkg

/* src/msf_top.sv */
// module: motor sequencer with stage code, status flags and fault handling
// How it works
// - command value 2 starts the drive; sequencer steps through start-up alone
// - command value 4 stops drive, all inverter switches off
// - stage register: idle 1, fault pending 1024, open-loop v/f 16384
// - stage: precharge 2, offset 4, catch-spin check 8, catch-spin brake 16
// - stage: park1 32, park2 64, open 128, transition 256, closed 512
// - start-success flag set on start success, cleared whenever drive stops
// - first-park flag set after quarter of total parking time
// - flags for park done, closed loop, start failed, two-phase modulation
// - fault bits 0..3: gate-kill, critical ov, bus ov, bus uv
// - fault bits 4..8: overspeed, zero speed, phase loss, start fail, engine
// - fault bits 9..12: catch-spin ov, engine exec, pfc gate-kill, converter comp
// - enabled fault latches, shuts drive down, raises interrupt
// - disable mask covers all faults except both gate-kills and critical ov
// - disabled fault still shows and interrupts, drive keeps running
// - disabled fault bit is not latched, follows the live condition
`timescale 1ns/1ps
module msf_top (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// register port
	input wire logic [7:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [15:0] reg_rdata,
	// fault sources, level, active high
	input wire logic [12:0] fault_in,
	// sequencer conditions from the drive
	input wire logic motor_spinning,
	input wire logic vf_mode,
	input wire logic start_fail_event,
	input wire logic two_phase_active,
	// drive outputs
	output logic drive_enable,
	output logic irq
);
	// ----------------------------------------
	// registers
	// ----------------------------------------
	msf_pkg::msf_stage_e stage_q;
	logic [15:0] step_cnt_q;
	logic [15:0] park_cnt_q;
	logic start_req_q;
	logic stop_req_q;
	logic start_ok_q;
	logic park_done_q;
	logic park_one_q;
	logic start_fail_q;
	logic [12:0] latched_q;
	logic [12:0] disable_q;
	logic clear_q;
	logic [1:0] irq_status_q;
	logic [1:0] irq_mask_q;
	logic [12:0] fault_bits;
	logic [12:0] mask_eff;
	logic [12:0] new_latch;
	logic trip;
	logic step_done;
	logic wr_cmd;
	logic [5:0] status_flags;
	logic [1:0] irq_ev;
	logic [1:0] irq_clr;

	// ----------------------------------------
	// fault logic
	// ----------------------------------------
	// only maskable sources honour the disable register
	assign mask_eff = disable_q & ~msf_pkg::FLT_UNMASKABLE;
	// enabled faults latch; disabled faults pass live
	assign new_latch = fault_in & ~mask_eff;
	assign fault_bits = latched_q | (fault_in & mask_eff);
	assign trip = |new_latch;
	assign wr_cmd = reg_write && (reg_addr == msf_pkg::ADDR_COMMAND);
	assign step_done = (step_cnt_q == 16'(msf_pkg::STEP_CYCLES - 1));

	// latched fault bits; clear register high holds them clear
	always_ff @(posedge clk) begin
		if (reset) begin
			latched_q <= 13'h0000;
		end else if (clear_q) begin
			latched_q <= 13'h0000;
		end else begin
			latched_q <= latched_q | new_latch;
		end
	end

	// clear and disable registers written by software
	always_ff @(posedge clk) begin
		if (reset) begin
			clear_q <= 1'b0;
			disable_q <= 13'h0000;
		end else if (reg_write) begin
			if (reg_addr == msf_pkg::ADDR_FAULT_CLEAR) begin
				clear_q <= reg_wdata[0];
			end
			if (reg_addr == msf_pkg::ADDR_FAULT_DISABLE) begin
				disable_q <= reg_wdata[12:0];
			end
		end
	end

	// ----------------------------------------
	// command capture
	// ----------------------------------------
	// start and stop requests registered as one-cycle pulses from command writes
	always_ff @(posedge clk) begin
		if (reset) begin
			start_req_q <= 1'b0;
			stop_req_q <= 1'b0;
		end else begin
			start_req_q <= (wr_cmd && reg_wdata == msf_pkg::CMD_START) ? 1'b1 : 1'b0;
			stop_req_q <= (wr_cmd && reg_wdata == msf_pkg::CMD_STOP) ? 1'b1 : 1'b0;
		end
	end

	// ----------------------------------------
	// sequencer
	// ----------------------------------------
	// step timer for each timed stage
	always_ff @(posedge clk) begin
		if (reset || step_done || stage_q == msf_pkg::ST_IDLE) begin
			step_cnt_q <= 16'h0000;
		end else begin
			step_cnt_q <= step_cnt_q + 16'h0001;
		end
	end

	// parking timer across both park stages
	always_ff @(posedge clk) begin
		if (reset || stage_q == msf_pkg::ST_IDLE) begin
			park_cnt_q <= 16'h0000;
		end else if ((stage_q == msf_pkg::ST_PARK1 || stage_q == msf_pkg::ST_PARK2)
				&& park_cnt_q != 16'(msf_pkg::PARK_CYCLES)) begin
			park_cnt_q <= park_cnt_q + 16'h0001;
		end
	end

	// stage machine, one code at a time
	always_ff @(posedge clk) begin
		if (reset) begin
			stage_q <= msf_pkg::ST_IDLE;
		end else if (trip && stage_q != msf_pkg::ST_IDLE) begin
			stage_q <= msf_pkg::ST_FAULT;
		end else if (stop_req_q) begin
			stage_q <= msf_pkg::ST_IDLE;
		end else begin
			unique case (stage_q)
				msf_pkg::ST_IDLE: begin
					if (start_req_q && !trip && latched_q == 13'h0000) begin
						stage_q <= vf_mode ? msf_pkg::ST_VF : msf_pkg::ST_PRECHARGE;
					end
				end
				msf_pkg::ST_PRECHARGE: begin
					if (step_done) stage_q <= msf_pkg::ST_OFFSET;
				end
				msf_pkg::ST_OFFSET: begin
					if (step_done) stage_q <= msf_pkg::ST_CS_CHECK;
				end
				msf_pkg::ST_CS_CHECK: begin
					if (step_done) begin
						stage_q <= motor_spinning ? msf_pkg::ST_CS_BRAKE : msf_pkg::ST_PARK1;
					end
				end
				msf_pkg::ST_CS_BRAKE: begin
					if (!motor_spinning) stage_q <= msf_pkg::ST_PARK1;
				end
				msf_pkg::ST_PARK1: begin
					if (park_cnt_q == 16'(msf_pkg::PARK_ONE_CYCLES)) begin
						stage_q <= msf_pkg::ST_PARK2;
					end
				end
				msf_pkg::ST_PARK2: begin
					if (park_cnt_q == 16'(msf_pkg::PARK_CYCLES)) begin
						stage_q <= msf_pkg::ST_OPEN_LOOP;
					end
				end
				msf_pkg::ST_OPEN_LOOP: begin
					if (start_fail_event) stage_q <= msf_pkg::ST_IDLE;
					else if (step_done) stage_q <= msf_pkg::ST_TRANSITION;
				end
				msf_pkg::ST_TRANSITION: begin
					if (step_done) stage_q <= msf_pkg::ST_CLOSED_LOOP;
				end
				msf_pkg::ST_CLOSED_LOOP: begin
					stage_q <= msf_pkg::ST_CLOSED_LOOP;
				end
				msf_pkg::ST_FAULT: begin
					if (latched_q == 13'h0000 && !trip) stage_q <= msf_pkg::ST_IDLE;
				end
				msf_pkg::ST_VF: begin
					stage_q <= msf_pkg::ST_VF;
				end
				default: begin
					stage_q <= msf_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------
	// status flags
	// ----------------------------------------
	// progress flags, all dropped when a start is requested in idle
	always_ff @(posedge clk) begin
		if (reset || stage_q == msf_pkg::ST_IDLE && start_req_q) begin
			start_ok_q <= 1'b0;
			park_done_q <= 1'b0;
			park_one_q <= 1'b0;
			start_fail_q <= 1'b0;
		end else begin
			if (stage_q == msf_pkg::ST_IDLE || stage_q == msf_pkg::ST_FAULT) begin
				start_ok_q <= 1'b0;
			end else if (stage_q == msf_pkg::ST_CLOSED_LOOP) begin
				start_ok_q <= 1'b1;
			end
			if (park_cnt_q >= 16'(msf_pkg::PARK_ONE_CYCLES)) begin
				park_one_q <= 1'b1;
			end
			if (park_cnt_q == 16'(msf_pkg::PARK_CYCLES)) begin
				park_done_q <= 1'b1;
			end
			if (stage_q == msf_pkg::ST_OPEN_LOOP && start_fail_event) begin
				start_fail_q <= 1'b1;
			end
		end
	end

	always_comb begin
		status_flags = 6'h00;
		status_flags[msf_pkg::SF_START_OK] = start_ok_q;
		status_flags[msf_pkg::SF_CLOSED_LOOP] = (stage_q == msf_pkg::ST_CLOSED_LOOP);
		status_flags[msf_pkg::SF_PARK_DONE] = park_done_q;
		status_flags[msf_pkg::SF_PARK_ONE] = park_one_q;
		status_flags[msf_pkg::SF_START_FAIL] = start_fail_q;
		status_flags[msf_pkg::SF_TWO_PHASE] = two_phase_active;
	end

	// ----------------------------------------
	// interrupts
	// ----------------------------------------
	// interrupt events and write-one clears of this cycle
	assign irq_ev[msf_pkg::IRQ_FAULT] = |fault_in;
	assign irq_ev[msf_pkg::IRQ_START_OK] = (stage_q == msf_pkg::ST_CLOSED_LOOP) && !start_ok_q;
	assign irq_clr = (reg_write && reg_addr == msf_pkg::ADDR_IRQ_STATUS) ? reg_wdata[1:0] : 2'h0;

	// sticky sources; a new event beats a write-one clear
	always_ff @(posedge clk) begin
		if (reset) begin
			irq_status_q <= 2'h0;
			irq_mask_q <= 2'h0;
		end else begin
			irq_status_q <= (irq_status_q & ~irq_clr) | irq_ev;
			if (reg_write && reg_addr == msf_pkg::ADDR_IRQ_MASK) irq_mask_q <= reg_wdata[1:0];
		end
	end

	// drive and interrupt outputs from flops
	always_ff @(posedge clk) begin
		if (reset) begin
			drive_enable <= 1'b0;
			irq <= 1'b0;
		end else begin
			drive_enable <= !(stage_q == msf_pkg::ST_IDLE || stage_q == msf_pkg::ST_FAULT
				|| trip || stop_req_q);
			irq <= |(irq_status_q & irq_mask_q);
		end
	end

	// ----------------------------------------
	// read port
	// ----------------------------------------
	// read data one cycle after the strobe, zero otherwise
	always_ff @(posedge clk) begin
		if (reset || !reg_read) begin
			reg_rdata <= 16'h0000;
		end else begin
			unique case (reg_addr)
				msf_pkg::ADDR_STAGE: reg_rdata <= stage_q;
				msf_pkg::ADDR_STATUS_FLAGS: reg_rdata <= {10'h000, status_flags};
				msf_pkg::ADDR_FAULT_BITS: reg_rdata <= {3'h0, fault_bits};
				msf_pkg::ADDR_FAULT_CLEAR: reg_rdata <= {15'h0000, clear_q};
				msf_pkg::ADDR_FAULT_DISABLE: reg_rdata <= {3'h0, disable_q};
				msf_pkg::ADDR_IRQ_STATUS: reg_rdata <= {14'h0000, irq_status_q};
				msf_pkg::ADDR_IRQ_MASK: reg_rdata <= {14'h0000, irq_mask_q};
				default: reg_rdata <= 16'h0000;
			endcase
		end
	end
endmodule : msf_top

/* bench/msf_mcu_model.sv */
// embedded controller model driving the register port
`timescale 1ns/1ps
module msf_mcu_model (
	// clock
	input wire logic clk,
	// register port
	output logic [7:0] reg_addr = 8'h00,
	output logic [15:0] reg_wdata = 16'h0000,
	output logic reg_write = 1'b0,
	output logic reg_read = 1'b0,
	input wire logic [15:0] reg_rdata
);
	// one-cycle write; released lines show the inverse
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge clk);
		reg_write <= 1'b0;
		reg_addr <= ~a;
		reg_wdata <= ~d;
	endtask : wr
	// one-cycle read, data taken in the next cycle
	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clk);
		reg_read <= 1'b0;
		reg_addr <= ~a;
		@(negedge clk);
		d = reg_rdata;
	endtask : rd
	// fault release: one, then zero
	task automatic fault_clear();
		wr(msf_pkg::ADDR_FAULT_CLEAR, 16'h0001);
		wr(msf_pkg::ADDR_FAULT_CLEAR, 16'h0000);
	endtask : fault_clear
endmodule : msf_mcu_model

/* bench/msf_top_props.sv */
// checker: port properties of the sequencer fault handler
`timescale 1ns/1ps
module msf_top_props (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// register port
	input wire logic [7:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	input wire logic [15:0] reg_rdata,
	// drive side
	input wire logic [12:0] fault_in,
	input wire logic two_phase_active,
	input wire logic drive_enable,
	input wire logic irq
);
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	logic start_wr, stop_wr, rd_q, stage_q, flt_q, flag_q, far_q, clr_q;
	assign start_wr = reg_write && reg_addr == msf_pkg::ADDR_COMMAND
		&& reg_wdata == msf_pkg::CMD_START;
	assign stop_wr = reg_write && reg_addr == msf_pkg::ADDR_COMMAND
		&& reg_wdata == msf_pkg::CMD_STOP;
	// mirror of the fault release register
	always_ff @(posedge clk) begin
		if (reset) begin
			clr_q <= 1'b0;
		end else if (reg_write && reg_addr == msf_pkg::ADDR_FAULT_CLEAR) begin
			clr_q <= reg_wdata[0];
		end
	end
	// remember what was read last cycle
	always_ff @(posedge clk) begin
		rd_q <= reg_read;
		stage_q <= reg_read && reg_addr == msf_pkg::ADDR_STAGE;
		flt_q <= reg_read && reg_addr == msf_pkg::ADDR_FAULT_BITS;
		flag_q <= reg_read && reg_addr == msf_pkg::ADDR_STATUS_FLAGS;
		far_q <= reg_read && reg_addr >= 8'h20;
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	// ----------------------------------------
	// assertions
	// ----------------------------------------
	rdata_idle_a: assert property (!rd_q |-> reg_rdata == 16'h0000)
		else $error("read data not zero outside a read");
	unmapped_zero_a: assert property (far_q |-> reg_rdata == 16'h0000)
		else $error("unmapped read not zero");
	stage_onehot_a: assert property (stage_q |-> $onehot(reg_rdata))
		else $error("stage code not one-hot");
	fault_top_zero_a: assert property (flt_q |-> reg_rdata[15:13] == 3'h0)
		else $error("unused fault bits set");
	fault_shown_a: assert property (flt_q && !$past(clr_q, 2) |-> (reg_rdata[12:0]
		& $past(fault_in, 2)) == ($past(fault_in) & $past(fault_in, 2)))
		else $error("standing fault not shown");
	kill_stops_a: assert property ((|(fault_in & msf_pkg::FLT_UNMASKABLE)) |-> ##[1:3] !drive_enable)
		else $error("unmaskable fault left drive on");
	stop_cmd_a: assert property (stop_wr |-> ##[1:2] !drive_enable)
		else $error("stop left drive on");
	start_delay_a: assert property ($rose(drive_enable) |-> $past(start_wr, 3))
		else $error("drive on without start");
	two_phase_a: assert property (flag_q
		&& $past(two_phase_active) == $past(two_phase_active, 3)
		|-> reg_rdata[msf_pkg::SF_TWO_PHASE] == $past(two_phase_active))
		else $error("two-phase flag wrong");
	// main scenarios
	cover property (start_wr);
	cover property ($fell(drive_enable));
	cover property (irq);
endmodule : msf_top_props
bind msf_top msf_top_props u_props (.clk, .reset, .reg_addr, .reg_wdata, .reg_write, .reg_read,
	.reg_rdata, .fault_in, .two_phase_active, .drive_enable, .irq);

/* bench/msf_top_tb_top.sv */
// testbench: register-level run of the sequencer fault handler
`timescale 1ns/1ps
module msf_top_tb_top;
	// ----------------------------------------
	// signals
	// ----------------------------------------
	logic clk, reset, reg_write, reg_read, drive_enable, irq;
	logic motor_spinning, vf_mode, start_fail_event, two_phase_active;
	logic [7:0] reg_addr;
	logic [12:0] fault_in;
	logic [15:0] reg_wdata, reg_rdata, rv, seen;
	logic [31:0] seed;
	int n_mismatch, total_checks, k, b;
	// design and controller model
	msf_top u_dut (.clk, .reset, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
		.fault_in, .motor_spinning, .vf_mode, .start_fail_event, .two_phase_active,
		.drive_enable, .irq);
	msf_mcu_model u_mcu (.clk, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata);
	// 50 ns clock
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction : xs
	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		total_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic rchk(input string nm, input logic [7:0] a, input logic [15:0] exp);
		u_mcu.rd(a, rv);
		chk(nm, exp, rv);
	endtask : rchk
	// poll stage, collecting every code seen
	task automatic wait_stage(input logic [15:0] st, input int lim);
		for (int i = 0; i < lim; i++) begin
			u_mcu.rd(msf_pkg::ADDR_STAGE, rv);
			seen = seen | rv;
			if (rv === st) break;
		end
		chk("stage", st, rv);
	endtask : wait_stage
	task automatic drive_fault(input logic [12:0] v);
		@(posedge clk);
		fault_in <= v;
		repeat (3) @(posedge clk);
	endtask : drive_fault
	task print_verdict();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : print_verdict
	// watchdog
	initial begin
		repeat (60000) @(posedge clk);
		n_mismatch++;
		print_verdict();
	end
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		seed = 32'h3e1b_4d1e;
		fault_in = 13'h0000;
		{motor_spinning, vf_mode, start_fail_event, two_phase_active} = 4'h0;
		reset = 1'b1;
		seen = 16'h0000;
		repeat (20) @(posedge clk);
		reset <= 1'b0;
		rchk("stage_rst", msf_pkg::ADDR_STAGE, msf_pkg::ST_IDLE);
		rchk("flags_rst", msf_pkg::ADDR_STATUS_FLAGS, 16'h0000);
		rchk("unmapped", 8'hfc, 16'h0000);
		// v/f start, then stop
		@(posedge clk);
		vf_mode <= 1'b1;
		u_mcu.wr(msf_pkg::ADDR_COMMAND, msf_pkg::CMD_START);
		wait_stage(msf_pkg::ST_VF, 20);
		u_mcu.wr(msf_pkg::ADDR_COMMAND, msf_pkg::CMD_STOP);
		wait_stage(msf_pkg::ST_IDLE, 20);
		chk("stopped", 16'h0000, {15'h0000, drive_enable});
		// full start-up to closed loop
		@(posedge clk);
		vf_mode <= 1'b0;
		two_phase_active <= 1'b1;
		motor_spinning <= 1'b1;
		seen = 16'h0000;
		u_mcu.wr(msf_pkg::ADDR_COMMAND, msf_pkg::CMD_START);
		wait_stage(msf_pkg::ST_CS_BRAKE, 4000);
		@(posedge clk);
		motor_spinning <= 1'b0;
		wait_stage(msf_pkg::ST_CLOSED_LOOP, 15000);
		chk("stages", 16'h03fe, seen & 16'h03fe);
		rchk("flags_run", msf_pkg::ADDR_STATUS_FLAGS, 16'h002f);
		// disabled random fault: live bit, irq, drive keeps running
		u_mcu.wr(msf_pkg::ADDR_IRQ_MASK, 16'h0001);
		u_mcu.wr(msf_pkg::ADDR_FAULT_DISABLE, 16'h1fff);
		for (k = 0; k < 4; k++) begin
			seed = xs(seed);
			b = 2 + int'(seed % 10);
			if (b == 11) b = 12;
			drive_fault(13'h0001 << b);
			rchk("live", msf_pkg::ADDR_FAULT_BITS, 16'h0001 << b);
			chk("runs", 16'h0001, {15'h0000, drive_enable});
			chk("irq_on", 16'h0001, {15'h0000, irq});
			drive_fault(13'h0000);
			rchk("gone", msf_pkg::ADDR_FAULT_BITS, 16'h0000);
			chk("irq_sticky", 16'h0001, {15'h0000, irq});
			u_mcu.wr(msf_pkg::ADDR_IRQ_STATUS, 16'h0003);
			repeat (2) @(negedge clk);
			chk("irq_off", 16'h0000, {15'h0000, irq});
		end
		u_mcu.wr(msf_pkg::ADDR_IRQ_MASK, 16'h0000);
		// unmaskable faults stop the drive and stay latched
		for (k = 0; k < 3; k++) begin
			b = (k == 2) ? 11 : k;
			if (k > 0) begin
				u_mcu.wr(msf_pkg::ADDR_COMMAND, msf_pkg::CMD_START);
				repeat (5) @(posedge clk);
				chk("restart", 16'h0001, {15'h0000, drive_enable});
			end
			drive_fault(13'h0001 << b);
			chk("drive_off", 16'h0000, {15'h0000, drive_enable});
			drive_fault(13'h0000);
			rchk("latched", msf_pkg::ADDR_FAULT_BITS, 16'h0001 << b);
			rchk("pending", msf_pkg::ADDR_STAGE, msf_pkg::ST_FAULT);
			chk("irq_masked", 16'h0000, {15'h0000, irq});
			u_mcu.fault_clear();
			rchk("released", msf_pkg::ADDR_FAULT_BITS, 16'h0000);
			wait_stage(msf_pkg::ST_IDLE, 20);
		end
		u_mcu.rd(msf_pkg::ADDR_STATUS_FLAGS, rv);
		chk("ok_clear", 16'h0000, rv & 16'h0001);
		// standing fault latches again once release returns to zero
		u_mcu.wr(msf_pkg::ADDR_FAULT_DISABLE, 16'h0000);
		drive_fault(13'h0008);
		u_mcu.fault_clear();
		drive_fault(13'h0000);
		rchk("relatch", msf_pkg::ADDR_FAULT_BITS, 16'h0008);
		// aborted start: open loop gives up, failure flag kept until next start
		u_mcu.fault_clear();
		u_mcu.wr(msf_pkg::ADDR_COMMAND, msf_pkg::CMD_START);
		wait_stage(msf_pkg::ST_OPEN_LOOP, 9000);
		@(posedge clk);
		start_fail_event <= 1'b1;
		wait_stage(msf_pkg::ST_IDLE, 20);
		@(posedge clk);
		start_fail_event <= 1'b0;
		rchk("flags_fail", msf_pkg::ADDR_STATUS_FLAGS, 16'h003c);
		chk("fail_off", 16'h0000, {15'h0000, drive_enable});
		print_verdict();
	end
endmodule : msf_top_tb_top
